/* File: rtl/eim_cfg.svh */
/*
  Register addresses, field positions and reset values of the external
  interrupt and extended mask block.
  Assumes an 8-bit special function register bus with 8-bit addresses.
*/
`ifndef EIM_CFG_SVH
`define EIM_CFG_SVH

// register addresses
`define EIM_ENABLE2_ADDR    8'hE7
`define EIM_PRIORITY2_ADDR  8'hF7
`define EIM_EXT_CFG_ADDR    8'hE4
`define EIM_TIMER_CTRL_ADDR 8'h88

// second extended enable and priority fields
`define EIM_SRC2_MSB          2
`define EIM_PIN_MATCH_BIT     2
`define EIM_CAN_BIT           1
`define EIM_REG_DROP_BIT      0

// external input configuration fields
`define EIM_A_SEL_LSB         0
`define EIM_A_POL_BIT         3
`define EIM_B_SEL_LSB         4
`define EIM_B_POL_BIT         7
`define EIM_SEL_W             3

// timer control fields held here
`define EIM_A_EDGE_BIT        0
`define EIM_A_PEND_BIT        1
`define EIM_B_EDGE_BIT        2
`define EIM_B_PEND_BIT        3

// reset values
`define EIM_ENABLE2_RESET     3'h0
`define EIM_PRIORITY2_RESET   3'h0
`define EIM_EXT_CFG_RESET     8'h00
`define EIM_EDGE_SEL_RESET    2'h0
`define EIM_PIN_IDLE_RESET    8'hFF

`endif

/* File: rtl/eim_ext_input.sv */
/*
  One external interrupt input: synchronises port 1, picks the selected
  pin, applies polarity and keeps the pending flag in edge or level mode.
  Assumes the port pins are asynchronous to i_mclk.
*/
`timescale 1ns/1ps
`include "eim_cfg.svh"

module eim_ext_input (
  // clock and reset
  input  wire logic                 i_mclk,
  input  wire logic                 i_reset,
  // pins
  input  wire logic [7:0]           i_port_pins,
  // configuration
  input  wire eim_pkg::eim_pin_sel_t i_pin_sel,
  input  wire logic                 i_polarity,
  input  wire logic                 i_edge_mode,
  // pending flag control
  input  wire logic                 i_vector_ack,
  input  wire logic                 i_sw_write,
  input  wire logic                 i_sw_pending,
  // status
  output logic                      o_pending,
  output logic                      o_active
);

  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic [7:0] sync3_r;
  logic [7:0] stable_r;
  logic       active;
  logic       active_prev_r;
  logic       rise;
  logic       pending_r;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      sync1_r <= `EIM_PIN_IDLE_RESET;
      sync2_r <= `EIM_PIN_IDLE_RESET;
      sync3_r <= `EIM_PIN_IDLE_RESET;
    end else begin
      sync1_r <= i_port_pins;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // a pin change counts once the last two stages agree
  for (genvar g = 0; g < 8; g++) begin : g_pin
    always_ff @(posedge i_mclk) begin
      if (i_reset) begin
        stable_r[g] <= 1'b1;
      end else if (sync2_r[g] == sync3_r[g]) begin
        stable_r[g] <= sync3_r[g];
      end
    end
  end

  // pin is only observed, never driven
  assign active = (stable_r[i_pin_sel] == i_polarity);
  assign rise   = active & ~active_prev_r;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      active_prev_r <= 1'b0;
    end else begin
      active_prev_r <= active;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      pending_r <= 1'b0;
    end else if (!i_edge_mode) begin
      pending_r <= active;
    end else if (rise) begin
      pending_r <= 1'b1;
    end else if (i_vector_ack) begin
      pending_r <= 1'b0;
    end else if (i_sw_write) begin
      pending_r <= i_sw_pending;
    end
  end

  assign o_pending = pending_r;
  assign o_active  = active;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  a_level_follow: assert property (!i_edge_mode |=> o_pending == $past(active))
    else $error("level pending does not follow input");
  a_edge_set: assert property (i_edge_mode && rise |=> o_pending)
    else $error("edge did not set pending");
  a_vector_clear: assert property (i_edge_mode && !rise && i_vector_ack |=> !o_pending)
    else $error("vectoring did not clear pending");
  // per pin: a taken level may only move where its last two stages agreed
  a_sync_agree: assert property (((stable_r ^ $past(stable_r))
      & ($past(sync2_r) ^ $past(sync3_r))) == 8'h00)
    else $error("pin level taken before stages agreed");

endmodule : eim_ext_input

/* File: rtl/eim_pkg.sv */
/*
  Types shared by the external interrupt and extended mask block.
  Assumes the constants of eim_cfg.svh for widths and positions.
*/
package eim_pkg;

  typedef logic [7:0] eim_byte_t;
  typedef logic [2:0] eim_pin_sel_t;

  // request vector index of each interrupt source
  typedef enum logic [2:0] {
    EIM_SRC_EXT_A = 3'h0,
    EIM_SRC_EXT_B = 3'h1,
    EIM_SRC_PM    = 3'h2,
    EIM_SRC_CAN   = 3'h3,
    EIM_SRC_REG   = 3'h4
  } eim_src_e;

endpackage : eim_pkg

/* File: rtl/eim_top.sv */
/*
  External interrupt inputs and second extended enable/priority registers.
  Assumes the CPU core reaches the registers over its special function
  register bus, and pulses a vector acknowledge per external input.
*/
`timescale 1ns/1ps
`include "eim_cfg.svh"

module eim_top (
  // clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_reset,
  // register bus
  input  wire logic [7:0]       i_sfr_addr,
  input  wire logic             i_sfr_wr,
  input  wire logic             i_sfr_rd,
  input  wire eim_pkg::eim_byte_t i_sfr_wdata,
  output eim_pkg::eim_byte_t    o_sfr_rdata,
  // port 1 pins
  input  wire logic [7:0]       i_port1,
  // CPU interrupt handshake
  input  wire logic [1:0]       i_ext_vector_ack,
  input  wire logic [1:0]       i_ext_enable,
  input  wire logic [1:0]       i_ext_priority,
  // other sources
  input  wire logic             i_pin_match_flag,
  input  wire logic             i_can_flag,
  input  wire logic             i_reg_dropout_flag,
  // requests to the CPU
  output logic [4:0]            o_req_high,
  output logic [4:0]            o_req_low
);

  logic [`EIM_SRC2_MSB:0] extended_irq_enable_second_r;
  logic [`EIM_SRC2_MSB:0] extended_irq_priority_second_r;
  eim_pkg::eim_byte_t     ext_input_config_register_r;
  logic [1:0]             edge_select_r;
  eim_pkg::eim_byte_t     rdata_r;
  eim_pkg::eim_byte_t     rdata_nxt;
  logic [4:0]             req_high_r;
  logic [4:0]             req_low_r;
  logic [4:0]             pending_vec;
  logic [4:0]             enable_vec;
  logic [4:0]             priority_vec;
  logic [1:0]             ext_pending;
  logic                   wr_enable2;
  logic                   wr_priority2;
  logic                   wr_ext_cfg;
  logic                   wr_timer_ctrl;

  assign wr_enable2    = i_sfr_wr && (i_sfr_addr == `EIM_ENABLE2_ADDR);
  assign wr_priority2  = i_sfr_wr && (i_sfr_addr == `EIM_PRIORITY2_ADDR);
  assign wr_ext_cfg    = i_sfr_wr && (i_sfr_addr == `EIM_EXT_CFG_ADDR);
  assign wr_timer_ctrl = i_sfr_wr && (i_sfr_addr == `EIM_TIMER_CTRL_ADDR);

  // only the low three bits are stored, upper bits of a write are dropped
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      extended_irq_enable_second_r <= `EIM_ENABLE2_RESET;
    end else if (wr_enable2) begin
      extended_irq_enable_second_r <= i_sfr_wdata[`EIM_SRC2_MSB:0];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      extended_irq_priority_second_r <= `EIM_PRIORITY2_RESET;
    end else if (wr_priority2) begin
      extended_irq_priority_second_r <= i_sfr_wdata[`EIM_SRC2_MSB:0];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ext_input_config_register_r <= `EIM_EXT_CFG_RESET;
    end else if (wr_ext_cfg) begin
      ext_input_config_register_r <= i_sfr_wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      edge_select_r <= `EIM_EDGE_SEL_RESET;
    end else if (wr_timer_ctrl) begin
      edge_select_r <= {i_sfr_wdata[`EIM_B_EDGE_BIT], i_sfr_wdata[`EIM_A_EDGE_BIT]};
    end
  end

  // the two external inputs; crossbar skip needs nothing here
  for (genvar g = 0; g < 2; g++) begin : g_ext
    localparam int SEL_LSB  = (g == 0) ? `EIM_A_SEL_LSB : `EIM_B_SEL_LSB;
    localparam int POL_BIT  = (g == 0) ? `EIM_A_POL_BIT : `EIM_B_POL_BIT;
    localparam int PEND_BIT = (g == 0) ? `EIM_A_PEND_BIT : `EIM_B_PEND_BIT;
    eim_ext_input u_ext (
      .i_mclk       (i_mclk),
      .i_reset      (i_reset),
      .i_port_pins  (i_port1),
      .i_pin_sel    (ext_input_config_register_r[SEL_LSB +: `EIM_SEL_W]),
      .i_polarity   (ext_input_config_register_r[POL_BIT]),
      .i_edge_mode  (edge_select_r[g]),
      .i_vector_ack (i_ext_vector_ack[g]),
      .i_sw_write   (wr_timer_ctrl),
      .i_sw_pending (i_sfr_wdata[PEND_BIT]),
      .o_pending    (ext_pending[g]),
      .o_active     ()
    );
  end

  // read data, registered one cycle after the read strobe
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (i_sfr_addr)
      `EIM_ENABLE2_ADDR: begin
        rdata_nxt[`EIM_SRC2_MSB:0] = extended_irq_enable_second_r;
      end
      `EIM_PRIORITY2_ADDR: begin
        rdata_nxt[`EIM_SRC2_MSB:0] = extended_irq_priority_second_r;
      end
      `EIM_EXT_CFG_ADDR: begin
        rdata_nxt = ext_input_config_register_r;
      end
      `EIM_TIMER_CTRL_ADDR: begin
        rdata_nxt[`EIM_A_EDGE_BIT] = edge_select_r[0];
        rdata_nxt[`EIM_A_PEND_BIT] = ext_pending[0];
        rdata_nxt[`EIM_B_EDGE_BIT] = edge_select_r[1];
        rdata_nxt[`EIM_B_PEND_BIT] = ext_pending[1];
      end
      default: begin
        rdata_nxt = 8'h00;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      rdata_r <= 8'h00;
    end else if (i_sfr_rd) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign o_sfr_rdata = rdata_r;

  // per-source request vectors
  always_comb begin
    pending_vec = 5'h00;
    enable_vec  = 5'h00;
    priority_vec = 5'h00;
    pending_vec[eim_pkg::EIM_SRC_EXT_A] = ext_pending[0];
    pending_vec[eim_pkg::EIM_SRC_EXT_B] = ext_pending[1];
    pending_vec[eim_pkg::EIM_SRC_PM]    = i_pin_match_flag;
    pending_vec[eim_pkg::EIM_SRC_CAN]   = i_can_flag;
    pending_vec[eim_pkg::EIM_SRC_REG]   = i_reg_dropout_flag;
    enable_vec[eim_pkg::EIM_SRC_EXT_A]  = i_ext_enable[0];
    enable_vec[eim_pkg::EIM_SRC_EXT_B]  = i_ext_enable[1];
    enable_vec[eim_pkg::EIM_SRC_PM]     = extended_irq_enable_second_r[`EIM_PIN_MATCH_BIT];
    enable_vec[eim_pkg::EIM_SRC_CAN]    = extended_irq_enable_second_r[`EIM_CAN_BIT];
    enable_vec[eim_pkg::EIM_SRC_REG]    = extended_irq_enable_second_r[`EIM_REG_DROP_BIT];
    priority_vec[eim_pkg::EIM_SRC_EXT_A] = i_ext_priority[0];
    priority_vec[eim_pkg::EIM_SRC_EXT_B] = i_ext_priority[1];
    priority_vec[eim_pkg::EIM_SRC_PM]  = extended_irq_priority_second_r[`EIM_PIN_MATCH_BIT];
    priority_vec[eim_pkg::EIM_SRC_CAN] = extended_irq_priority_second_r[`EIM_CAN_BIT];
    priority_vec[eim_pkg::EIM_SRC_REG] = extended_irq_priority_second_r[`EIM_REG_DROP_BIT];
  end

  // a level source left active after its routine simply requests again
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      req_high_r <= 5'h00;
      req_low_r  <= 5'h00;
    end else begin
      req_high_r <= pending_vec & enable_vec & priority_vec;
      req_low_r  <= pending_vec & enable_vec & ~priority_vec;
    end
  end

  assign o_req_high = req_high_r;
  assign o_req_low  = req_low_r;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  a_unused_zero: assert property (i_sfr_rd && (i_sfr_addr == `EIM_ENABLE2_ADDR ||
      i_sfr_addr == `EIM_PRIORITY2_ADDR) |=> o_sfr_rdata[7:3] == 5'h00)
    else $error("unused bits of enable or priority read nonzero");
  a_pm_gate: assert property (!extended_irq_enable_second_r[`EIM_PIN_MATCH_BIT]
      |=> !o_req_high[eim_pkg::EIM_SRC_PM] && !o_req_low[eim_pkg::EIM_SRC_PM])
    else $error("port match request passed while disabled");
  a_can_gate: assert property (i_can_flag && extended_irq_enable_second_r[`EIM_CAN_BIT]
      |=> o_req_high[eim_pkg::EIM_SRC_CAN] || o_req_low[eim_pkg::EIM_SRC_CAN])
    else $error("enabled CAN request did not pass");
  a_reg_gate: assert property (wr_enable2 && !i_sfr_wdata[`EIM_REG_DROP_BIT]
      |=> ##1 !o_req_high[eim_pkg::EIM_SRC_REG] && !o_req_low[eim_pkg::EIM_SRC_REG])
    else $error("dropout request passed after disable write");
  a_pm_prio: assert property (i_pin_match_flag
      && extended_irq_enable_second_r[`EIM_PIN_MATCH_BIT]
      |=> o_req_high[eim_pkg::EIM_SRC_PM] == $past(priority_vec[eim_pkg::EIM_SRC_PM]))
    else $error("port match at wrong priority level");
  a_can_prio: assert property (o_req_low[eim_pkg::EIM_SRC_CAN]
      |-> !$past(extended_irq_priority_second_r[`EIM_CAN_BIT]))
    else $error("CAN request low while priority high");
  a_reg_prio: assert property (o_req_high[eim_pkg::EIM_SRC_REG]
      |-> $past(extended_irq_priority_second_r[`EIM_REG_DROP_BIT]) && $past(i_reg_dropout_flag))
    else $error("dropout request high without cause");
  a_pend_read: assert property (i_sfr_rd && i_sfr_addr == `EIM_TIMER_CTRL_ADDR
      |=> o_sfr_rdata[`EIM_A_PEND_BIT] == $past(ext_pending[0])
          && o_sfr_rdata[`EIM_B_PEND_BIT] == $past(ext_pending[1]))
    else $error("pending flags read at wrong bits");
  a_ext_request: assert property ((o_req_high[eim_pkg::EIM_SRC_EXT_A]
      || o_req_low[eim_pkg::EIM_SRC_EXT_A]) |-> $past(ext_pending[0]) && $past(i_ext_enable[0]))
    else $error("external request without pending and enable");

endmodule : eim_top

/* File: verif/eim_src_model.sv */
/*
  Behavioural external interrupt sources standing on port 1.
  Assumes the bench names the two watched pins; all other pins toggle each cycle.
*/
`timescale 1ns/1ps

module eim_src_model (
  // clock
  input  wire logic       i_mclk,
  // watched pins
  input  wire logic [2:0] i_sel_a,
  input  wire logic [2:0] i_sel_b,
  // port 1
  output logic [7:0]      o_pins
);
  logic [7:0] held_r;
  logic [7:0] noise_r;

  initial begin
    held_r  = 8'hFF;
    noise_r = 8'h5A;
  end

  // unwatched pins change every cycle so a wrong pin select shows up
  always @(posedge i_mclk) begin
    #1 noise_r = ~noise_r;
  end

  always_comb begin
    o_pins          = noise_r;
    o_pins[i_sel_a] = held_r[i_sel_a];
    o_pins[i_sel_b] = held_r[i_sel_b];
  end

  // a source holds its pin at the level last given by drive until the bench drives it again
  task automatic drive(input logic [2:0] pin, input logic val);
    held_r[pin] = val;
  endtask : drive
endmodule : eim_src_model

/* File: verif/tb_top.sv */
/*
  Self-checking bench of the external interrupt and extended mask block.
  Assumes eim_top and the source model eim_src_model on port 1.
*/
`timescale 1ns/1ps
`include "eim_cfg.svh"

module tb_top;
  logic              i_mclk;
  logic              i_reset;
  logic [7:0]        i_sfr_addr;
  logic              i_sfr_wr;
  logic              i_sfr_rd;
  eim_pkg::eim_byte_t i_sfr_wdata;
  eim_pkg::eim_byte_t o_sfr_rdata;
  logic [7:0]        pins;
  logic [1:0]        i_ext_vector_ack;
  logic [1:0]        i_ext_enable;
  logic [1:0]        i_ext_priority;
  logic              i_pin_match_flag;
  logic              i_can_flag;
  logic              i_reg_dropout_flag;
  logic [4:0]        o_req_high;
  logic [4:0]        o_req_low;
  logic [2:0]        sel_a;
  logic [2:0]        sel_b;
  logic [7:0]        en;
  logic [7:0]        pr;
  logic [2:0]        src;
  logic [2:0]        prl;
  logic              pol_a;
  logic              pol_b;
  int                err_total;
  int                checked;
  int                seed;
  int                ea;
  int                eb;
  int                pend_a;
  int                pend_b;

  eim_top u_dut (
    .i_mclk             (i_mclk),
    .i_reset            (i_reset),
    .i_sfr_addr         (i_sfr_addr),
    .i_sfr_wr           (i_sfr_wr),
    .i_sfr_rd           (i_sfr_rd),
    .i_sfr_wdata        (i_sfr_wdata),
    .o_sfr_rdata        (o_sfr_rdata),
    .i_port1            (pins),
    .i_ext_vector_ack   (i_ext_vector_ack),
    .i_ext_enable       (i_ext_enable),
    .i_ext_priority     (i_ext_priority),
    .i_pin_match_flag   (i_pin_match_flag),
    .i_can_flag         (i_can_flag),
    .i_reg_dropout_flag (i_reg_dropout_flag),
    .o_req_high         (o_req_high),
    .o_req_low          (o_req_low)
  );

  eim_src_model u_src (
    .i_mclk  (i_mclk),
    .i_sel_a (sel_a),
    .i_sel_b (sel_b),
    .o_pins  (pins)
  );

  always #5 i_mclk = ~i_mclk;

  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : tick

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_sfr_addr  = a;
    i_sfr_wdata = d;
    i_sfr_wr    = 1'b1;
    tick(1);
    i_sfr_wr = 1'b0;
    tick(1);
  endtask : wr

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
    i_sfr_addr = a;
    i_sfr_rd   = 1'b1;
    tick(1);
    i_sfr_rd = 1'b0;
    tick(1);
    chk(name, o_sfr_rdata, exp);
  endtask : rd_chk

  function automatic logic [7:0] exp_tc();
    return 8'(pend_b * 8 + eb * 4 + pend_a * 2 + ea);
  endfunction : exp_tc

  task automatic req_chk();
    logic [1:0] p;
    p = {1'(pend_b), 1'(pend_a)};
    chk("req_high", {3'h0, o_req_high}, {6'h0, p & i_ext_priority});
    chk("req_low", {3'h0, o_req_low}, {6'h0, p & ~i_ext_priority});
  endtask : req_chk

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  initial begin
    tick(5000);
    err_total++;
    conclude();
  end

  initial begin
    i_mclk = 1'b0;
    i_reset = 1'b1;
    i_sfr_addr = 8'h00;
    i_sfr_wr = 1'b0;
    i_sfr_rd = 1'b0;
    i_sfr_wdata = 8'h00;
    i_ext_vector_ack = 2'h0;
    i_ext_enable = 2'h3;
    i_ext_priority = 2'h0;
    {i_reg_dropout_flag, i_can_flag, i_pin_match_flag} = 3'h0;
    sel_a = 3'h0;
    sel_b = 3'h0;
    err_total = 0;
    checked = 0;
    seed = 22026;
    tick(16);
    i_reset = 1'b0;
    tick(1);
    rd_chk("enable2", `EIM_ENABLE2_ADDR, 8'h00);
    rd_chk("priority2", `EIM_PRIORITY2_ADDR, 8'h00);
    rd_chk("ext_cfg", `EIM_EXT_CFG_ADDR, 8'h00);
    rd_chk("timer_ctrl", `EIM_TIMER_CTRL_ADDR, 8'h00);
    wr(`EIM_ENABLE2_ADDR, 8'hFF);
    wr(`EIM_PRIORITY2_ADDR, 8'hF8);
    rd_chk("enable2", `EIM_ENABLE2_ADDR, 8'h07);
    rd_chk("priority2", `EIM_PRIORITY2_ADDR, 8'h00);
    wr(8'h55, 8'hFF);
    rd_chk("unmapped", 8'h55, 8'h00);
    // other sources: random masks, levels and flags
    for (int i = 0; i < 24; i++) begin
      en = 8'($random(seed));
      pr = 8'($random(seed));
      wr(`EIM_ENABLE2_ADDR, en);
      wr(`EIM_PRIORITY2_ADDR, pr);
      {i_reg_dropout_flag, i_can_flag, i_pin_match_flag} = 3'($random(seed));
      i_ext_enable = 2'($random(seed));
      i_ext_priority = 2'($random(seed));
      tick(3);
      src = {i_reg_dropout_flag & en[0], i_can_flag & en[1], i_pin_match_flag & en[2]};
      prl = {pr[0], pr[1], pr[2]};
      chk("src_high", {3'h0, o_req_high}, {1'b0, src & prl, 4'h0} >> 2);
      chk("src_low", {3'h0, o_req_low}, {1'b0, src & ~prl, 4'h0} >> 2);
    end
    {i_reg_dropout_flag, i_can_flag, i_pin_match_flag} = 3'h0;
    i_ext_enable = 2'h3;
    // external inputs: every pin code, every sense and polarity
    for (int i = 0; i < 8; i++) begin
      ea = i % 2;
      eb = 1 - ea;
      pol_a = 1'((i / 2) % 2);
      pol_b = ~pol_a;
      sel_a = 3'(i);
      sel_b = 3'(7 - i);
      u_src.drive(sel_a, ~pol_a);
      u_src.drive(sel_b, ~pol_b);
      i_ext_priority = 2'(i);
      wr(`EIM_EXT_CFG_ADDR, {pol_b, sel_b, pol_a, sel_a});
      wr(`EIM_TIMER_CTRL_ADDR, 8'(eb * 4 + ea));
      tick(8);
      wr(`EIM_TIMER_CTRL_ADDR, 8'(eb * 4 + ea));
      tick(4);
      pend_a = 0;
      pend_b = 0;
      rd_chk("timer_ctrl", `EIM_TIMER_CTRL_ADDR, exp_tc());
      u_src.drive(sel_a, pol_a);
      u_src.drive(sel_b, pol_b);
      tick(8);
      pend_a = 1;
      pend_b = 1;
      rd_chk("timer_ctrl", `EIM_TIMER_CTRL_ADDR, exp_tc());
      req_chk();
      u_src.drive(sel_a, ~pol_a);
      u_src.drive(sel_b, ~pol_b);
      tick(8);
      pend_a = ea;
      pend_b = eb;
      rd_chk("timer_ctrl", `EIM_TIMER_CTRL_ADDR, exp_tc());
      req_chk();
      i_ext_vector_ack = 2'h3;
      tick(1);
      i_ext_vector_ack = 2'h0;
      tick(4);
      pend_a = 0;
      pend_b = 0;
      rd_chk("timer_ctrl", `EIM_TIMER_CTRL_ADDR, exp_tc());
      req_chk();
      // software sets pending in edge mode; level mode ignores the write
      wr(`EIM_TIMER_CTRL_ADDR, 8'(eb * 12 + ea * 3));
      pend_a = ea;
      pend_b = eb;
      rd_chk("timer_ctrl", `EIM_TIMER_CTRL_ADDR, exp_tc());
      req_chk();
    end
    // second reset in mid-run brings every register back to its reset value
    i_reset = 1'b1;
    tick(2);
    i_reset = 1'b0;
    tick(1);
    ea = 0;
    eb = 0;
    pend_a = 0;
    pend_b = 0;
    rd_chk("enable2", `EIM_ENABLE2_ADDR, 8'h00);
    rd_chk("priority2", `EIM_PRIORITY2_ADDR, 8'h00);
    rd_chk("ext_cfg", `EIM_EXT_CFG_ADDR, 8'h00);
    rd_chk("timer_ctrl", `EIM_TIMER_CTRL_ADDR, exp_tc());
    req_chk();
    conclude();
  end
endmodule : tb_top
